// ### src/rms_pkg.sv
// shared constants and types for the receiver mode register bank
package rms_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register port
  localparam int unsigned RMS_AW = 8;
  localparam int unsigned RMS_DW = 8;

  localparam logic [RMS_AW-1:0] RMS_MODE_ADDR = 8'h23;
  localparam logic [RMS_AW-1:0] RMS_CPS_ADDR  = 8'h40;
  localparam logic [RMS_AW-1:0] RMS_MASK_ADDR = 8'h41;
  localparam logic [RMS_DW-1:0] RMS_RD_IDLE   = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // mode register layout, msb first
  typedef struct packed {
    logic       chk_en;      // line checksum check enable
    logic       rate_pick;   // 0 divide by four, 1 divide by two
    logic       audio_auto;  // audio mode from aux codes
    logic       fast;        // high-speed return link
    logic       coax;        // 0 twisted pair, 1 coax
    logic       repeater;    // strapped repeater, read only
    logic [1:0] rsvd;
  } rms_mode_type;

  localparam rms_mode_type RMS_MODE_RST = 8'h20;

  // strap levels of the first mode-select pin
  typedef struct packed {
    logic fast;
    logic coax;
    logic repeater;
  } rms_strap_type;

  ////////////////////////////////////////////////////////////////////////
  // status and mask bits
  localparam int unsigned RMS_ST_W    = 2;
  localparam int unsigned RMS_ST_CHK  = 0;
  localparam int unsigned RMS_ST_RATE = 1;

  ////////////////////////////////////////////////////////////////////////
  // return link rate
  typedef enum logic [1:0] {
    RMS_RATE_DIV4 = 2'h0,
    RMS_RATE_DIV2 = 2'h1,
    RMS_RATE_FAST = 2'h2
  } rms_rate_type;

  localparam int unsigned RMS_CLK_KHZ   = 50000;
  localparam int unsigned RMS_FAST_KBPS = 20000;
  // bit period rounds down: never slower than the nominal fast rate
  localparam int unsigned RMS_FAST_DIV  =
    (RMS_CLK_KHZ / RMS_FAST_KBPS) < 1 ? 1 : RMS_CLK_KHZ / RMS_FAST_KBPS;
  localparam int unsigned RMS_DIV2_SH   = 1;
  localparam int unsigned RMS_DIV4_SH   = 2;

endpackage

// ### src/rms_strap_capture.sv
// catches the mode-select strap once after reset release
`timescale 1ns/1ns
`default_nettype none

module rms_strap_capture (
  input  wire logic                   clk_i,
  input  wire logic                   srst_i,
  input  wire rms_pkg::rms_strap_type pin_i,
  output rms_pkg::rms_strap_type      strap_o,
  output logic                        load_o
);
  import rms_pkg::*;

  rms_strap_type strap_q;
  logic          done_q;
  logic          load_q;

  ////////////////////////////////////////////////////////////////////////
  // reset takes constants only; pin is sampled at first free edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      strap_q <= '0;
      done_q  <= 1'b0;
      load_q  <= 1'b0;
    end else if (!done_q) begin
      strap_q <= pin_i;
      done_q  <= 1'b1;
      load_q  <= 1'b1;
    end else begin
      load_q  <= 1'b0;
    end
  end

  assign strap_o = strap_q;
  assign load_o  = load_q;

  strap_once_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    load_o |=> !load_o) else $error("strap load repeated");

endmodule // rms_strap_capture

`default_nettype wire

// ### src/rms_line_checksum.sv
// per-line byte sum with compare against the appended checksum byte
`timescale 1ns/1ns
`default_nettype none

module rms_line_checksum #(
  parameter int unsigned BW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          srst_i,
  input  wire logic          en_i,
  input  wire logic          byte_vld_i,
  input  wire logic [BW-1:0] byte_i,
  input  wire logic          sum_byte_i,
  output logic               err_o
);

  logic [BW-1:0] sum_q;
  logic          err_q;

  ////////////////////////////////////////////////////////////////////////
  // sum restarts at every line end, checked or not
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sum_q <= '0;
    end else if (byte_vld_i && sum_byte_i) begin
      sum_q <= '0;
    end else if (byte_vld_i) begin
      sum_q <= sum_q + byte_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      err_q <= 1'b0;
    end else begin
      err_q <= en_i && byte_vld_i && sum_byte_i && (byte_i != sum_q);
    end
  end

  assign err_o = err_q;

  chk_gate_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    err_o |-> $past(en_i) && $past(sum_byte_i) && $past(byte_vld_i))
    else $error("checksum error without enabled check");

endmodule // rms_line_checksum

`default_nettype wire

// ### src/rms_mode_reg_top.sv
// receiver mode register bank with return link rate and line checks
`timescale 1ns/1ns
`default_nettype none
//
// Operation
// - bit 7 enables checking of the checksum byte after each line
// - checksum mismatches are flagged in the protection status register
// - bit 6 picks return link divide by four (0) or two (1)
// - high-speed bit set makes the divided-rate pick ignored
// - bit 4 runs the return link at the fast rate, 25 Mbps from the 50 MHz clock
// - rate changes may cause brief link errors; not suppressed
// - bit 5, reset one, derives audio mode from aux codes
// - bit 3 selects twisted pair (0) or coax (1) cabling
// - fast, coax and repeater bits load from strap pin one
// - bit 2 is read-only repeater strap indication
//
module rms_mode_reg_top #(
  parameter int unsigned OSCW = 8
) (
  input  wire logic                        clk_i,
  input  wire logic                        srst_i,
  input  wire logic [rms_pkg::RMS_AW-1:0]  addr_i,
  input  wire logic [rms_pkg::RMS_DW-1:0]  wr_data_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [rms_pkg::RMS_DW-1:0]  rd_data_o,
  input  wire rms_pkg::rms_strap_type      config_strap_pin_one_i,
  input  wire logic [OSCW-1:0]             oscillator_divider_setting_i,
  input  wire logic                        line_byte_vld_i,
  input  wire logic [7:0]                  line_byte_i,
  input  wire logic                        line_sum_byte_i,
  output logic                             line_checksum_check_en_o,
  output logic                             return_link_rate_pick_o,
  output logic                             audio_auto_detect_o,
  output logic                             return_link_fast_o,
  output logic                             coax_mode_o,
  output logic                             repeater_mode_o,
  output rms_pkg::rms_rate_type            return_link_rate_o,
  output logic                             return_link_tick_o,
  output logic                             irq_o
);
  import rms_pkg::*;

  localparam int unsigned CW = OSCW + 3;

  ////////////////////////////////////////////////////////////////////////
  // declarations
  rms_mode_type          mode_q;
  rms_mode_type          wdata;
  rms_strap_type         strap;
  logic                  strap_load;
  logic                  chk_err;
  logic [RMS_ST_W-1:0]   st_q;
  logic [RMS_ST_W-1:0]   st_set;
  logic [RMS_ST_W-1:0]   st_clr;
  logic [RMS_ST_W-1:0]   mask_q;
  logic [RMS_DW-1:0]     rd_q;
  rms_rate_type          rate_q;
  rms_rate_type          rate_d;
  logic [CW-1:0]         cnt_q;
  logic [CW-1:0]         period;
  logic [CW-1:0]         osc_base;
  logic                  tick_q;
  logic                  irq_q;
  logic                  wr_mode;
  logic                  wr_st;
  logic                  wr_mask;

  function automatic logic hit(input logic [RMS_AW-1:0] a,
                               input logic [RMS_AW-1:0] r);
    return a == r;
  endfunction

  assign wdata   = rms_mode_type'(wr_data_i);
  assign wr_mode = wr_i && hit(addr_i, RMS_MODE_ADDR);
  assign wr_st   = wr_i && hit(addr_i, RMS_CPS_ADDR);
  assign wr_mask = wr_i && hit(addr_i, RMS_MASK_ADDR);

  ////////////////////////////////////////////////////////////////////////
  // strap capture and line checker
  rms_strap_capture u_strap (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .pin_i   (config_strap_pin_one_i),
    .strap_o (strap),
    .load_o  (strap_load)
  );

  rms_line_checksum #(
    .BW (8)
  ) u_chk (
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .en_i       (mode_q.chk_en),
    .byte_vld_i (line_byte_vld_i),
    .byte_i     (line_byte_i),
    .sum_byte_i (line_sum_byte_i),
    .err_o      (chk_err)
  );

  ////////////////////////////////////////////////////////////////////////
  // mode register
  // strap load wins over a write in the same cycle; hosts wait for it
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_q <= RMS_MODE_RST;
    end else if (strap_load) begin
      mode_q.fast     <= strap.fast;
      mode_q.coax     <= strap.coax;
      mode_q.repeater <= strap.repeater;
    end else if (wr_mode) begin
      mode_q.chk_en     <= wdata.chk_en;
      mode_q.rate_pick  <= wdata.rate_pick;
      mode_q.audio_auto <= wdata.audio_auto;
      mode_q.fast       <= wdata.fast;
      mode_q.coax       <= wdata.coax;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // return link rate
  always_comb begin
    if (mode_q.fast) begin
      rate_d = RMS_RATE_FAST;
    end else if (mode_q.rate_pick) begin
      rate_d = RMS_RATE_DIV2;
    end else begin
      rate_d = RMS_RATE_DIV4;
    end
  end

  // applied at once; the link may see a few errors meanwhile
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rate_q <= RMS_RATE_DIV4;
    end else begin
      rate_q <= rate_d;
    end
  end

  assign osc_base = CW'(oscillator_divider_setting_i) + CW'(1);

  always_comb begin
    case (rate_q)
      RMS_RATE_FAST: period = CW'(RMS_FAST_DIV);
      RMS_RATE_DIV2: period = osc_base << RMS_DIV2_SH;
      default:       period = osc_base << RMS_DIV4_SH;
    endcase
  end

  // counter restarts on a rate change so no stretched bit remains
  // compare is >= so a smaller divider never strands the count
  always_ff @(posedge clk_i) begin
    if (srst_i || (rate_d != rate_q)) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q >= period - CW'(1)) begin
      cnt_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + CW'(1);
      tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status, mask and interrupt
  always_comb begin
    st_set              = '0;
    st_set[RMS_ST_CHK]  = chk_err;
    st_set[RMS_ST_RATE] = rate_d != rate_q;
    st_clr              = wr_st ? wr_data_i[RMS_ST_W-1:0] : '0;
  end

  // set beats clear so no event is lost
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_q <= '0;
    end else begin
      st_q <= (st_q & ~st_clr) | st_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mask_q <= '0;
    end else if (wr_mask) begin
      mask_q <= wr_data_i[RMS_ST_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(st_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port, data valid only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (srst_i || !rd_i) begin
      rd_q <= RMS_RD_IDLE;
    end else if (hit(addr_i, RMS_MODE_ADDR)) begin
      rd_q <= {mode_q[RMS_DW-1:2], 2'h0};
    end else if (hit(addr_i, RMS_CPS_ADDR)) begin
      rd_q <= RMS_DW'(st_q);
    end else if (hit(addr_i, RMS_MASK_ADDR)) begin
      rd_q <= RMS_DW'(mask_q);
    end else begin
      rd_q <= RMS_RD_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign rd_data_o                = rd_q;
  assign line_checksum_check_en_o = mode_q.chk_en;
  assign return_link_rate_pick_o  = mode_q.rate_pick;
  assign audio_auto_detect_o      = mode_q.audio_auto;
  assign return_link_fast_o       = mode_q.fast;
  assign coax_mode_o              = mode_q.coax;
  assign repeater_mode_o          = mode_q.repeater;
  assign return_link_rate_o       = rate_q;
  assign return_link_tick_o       = tick_q;
  assign irq_o                    = irq_q;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  err_to_status_a: assert property (
    chk_err |=> st_q[RMS_ST_CHK])
    else $error("checksum error not flagged in status");

  div_pick_a: assert property (
    !$past(mode_q.fast) |-> return_link_rate_o ==
      ($past(mode_q.rate_pick) ? RMS_RATE_DIV2 : RMS_RATE_DIV4))
    else $error("divided rate does not follow pick bit");

  fast_over_pick_a: assert property (
    $past(mode_q.fast) |-> return_link_rate_o == RMS_RATE_FAST)
    else $error("fast bit did not override rate pick");

  fast_tick_a: assert property (
    (return_link_tick_o && return_link_rate_o == RMS_RATE_FAST) ##1
    (return_link_rate_o == RMS_RATE_FAST)[*2]
    |-> !$past(return_link_tick_o) && return_link_tick_o)
    else $error("fast tick spacing wrong");

  audio_reset_a: assert property (
    $fell(srst_i) |-> audio_auto_detect_o && !line_checksum_check_en_o)
    else $error("audio auto bit not set after reset");

  coax_write_a: assert property (
    wr_mode && !strap_load |=> coax_mode_o == $past(wdata.coax))
    else $error("cable type bit not written");

  strap_load_a: assert property (
    strap_load |=> return_link_fast_o == $past(strap.fast) &&
                   coax_mode_o == $past(strap.coax) &&
                   repeater_mode_o == $past(strap.repeater))
    else $error("strap values not loaded");

  repeater_ro_a: assert property (
    wr_mode && !strap_load |=> $stable(repeater_mode_o))
    else $error("repeater bit changed by write");

  rsvd_zero_a: assert property (
    rd_i && hit(addr_i, RMS_MODE_ADDR) |=>
      rd_data_o[1:0] == 2'h0 && rd_data_o[2] == $past(repeater_mode_o))
    else $error("reserved mode bits not zero");

  fast_write_a: assert property (
    wr_mode && !strap_load ##1 !wr_mode && !strap_load
    |=> return_link_fast_o == $past(wdata.fast, 2))
    else $error("write did not override strapped fast bit");

  chk_off_a: assert property (
    !mode_q.chk_en |=> !chk_err)
    else $error("line check ran while disabled");

  status_w1c_a: assert property (
    wr_st && wr_data_i[RMS_ST_CHK] && !chk_err |=> !st_q[RMS_ST_CHK])
    else $error("status bit not cleared by write");

  irq_level_a: assert property (
    irq_o == $past(|(st_q & mask_q)))
    else $error("interrupt does not follow status and mask");

  rate_restart_a: assert property (
    rate_d != rate_q |=> !return_link_tick_o && cnt_q == '0)
    else $error("rate change did not restart bit counter");

  audio_write_a: assert property (
    wr_mode && !strap_load |=>
      audio_auto_detect_o == $past(wdata.audio_auto))
    else $error("audio auto bit not written");

endmodule // rms_mode_reg_top

`default_nettype wire

// ### verif/rms_line_src.sv
// far-end model: sends video lines with an appended checksum byte
`timescale 1ns/1ns
`default_nettype none

module rms_line_src (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       go_i,
  input  wire logic       bad_i,
  input  wire logic       slow_i,
  output logic            vld_o,
  output logic [7:0]      byte_o,
  output logic            sum_o,
  output logic            busy_o
);
  logic [1:0] idx_q;
  logic       gap_q;
  logic [7:0] val;

  ////////////////////////////////////////////////////////////////////////
  // line is 01 02 03 then sum 06; bad lines corrupt the sum byte
  // remote end taken to be in auto-ack before any rate change
  always_comb begin
    case (idx_q)
      2'h0: val = 8'h01;
      2'h1: val = 8'h02;
      2'h2: val = 8'h03;
      default: val = bad_i ? 8'h07 : 8'h06;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      busy_o <= 1'b0;
      vld_o  <= 1'b0;
      sum_o  <= 1'b0;
      byte_o <= 8'h00;
      idx_q  <= 2'h0;
      gap_q  <= 1'b0;
    end else if (!busy_o) begin
      vld_o  <= 1'b0;
      sum_o  <= 1'b0;
      byte_o <= ~byte_o; // idle data never holds the last byte
      busy_o <= go_i;
      idx_q  <= 2'h0;
      gap_q  <= 1'b0;
    end else if (slow_i && !gap_q) begin
      vld_o  <= 1'b0;
      sum_o  <= 1'b0;
      byte_o <= ~byte_o;
      gap_q  <= 1'b1;
    end else begin
      vld_o  <= 1'b1;
      byte_o <= val;
      sum_o  <= (idx_q == 2'h3);
      idx_q  <= idx_q + 2'h1;
      gap_q  <= 1'b0;
      busy_o <= (idx_q != 2'h3);
    end
  end
endmodule // rms_line_src
`default_nettype wire

// ### verif/tb_rms_mode_reg_top.sv
// testbench for the receiver mode register bank
`timescale 1ns/1ns
`default_nettype none

module tb_rms_mode_reg_top;
  import rms_pkg::*;
  logic          clk_i = 1'b0;
  logic          srst_i = 1'b1;
  logic [7:0]    addr_i = 8'h00;
  logic [7:0]    wr_data_i = 8'h00;
  logic          wr_i = 1'b0;
  logic          rd_i = 1'b0;
  logic [7:0]    rd_data_o;
  rms_strap_type strap = 3'h5;
  logic [7:0]    osc_n = 8'h02;
  logic          vld, sumb, busy, go = 1'b0, bad = 1'b0, slow = 1'b0;
  logic [7:0]    lbyte;
  logic          chk_en, pick, audio, fast, coax, rep, tick, irq;
  rms_rate_type  rate;
  int            bad_count = 0;
  int            num_checks = 0;

  always #10 clk_i = ~clk_i;

  rms_mode_reg_top #(.OSCW(8)) i_dut (
    .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .config_strap_pin_one_i(strap),
    .oscillator_divider_setting_i(osc_n), .line_byte_vld_i(vld),
    .line_byte_i(lbyte), .line_sum_byte_i(sumb),
    .line_checksum_check_en_o(chk_en), .return_link_rate_pick_o(pick),
    .audio_auto_detect_o(audio), .return_link_fast_o(fast),
    .coax_mode_o(coax), .repeater_mode_o(rep),
    .return_link_rate_o(rate), .return_link_tick_o(tick), .irq_o(irq));

  rms_line_src i_src (
    .clk_i(clk_i), .srst_i(srst_i), .go_i(go), .bad_i(bad),
    .slow_i(slow), .vld_o(vld), .byte_o(lbyte), .sum_o(sumb),
    .busy_o(busy));

  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic do_reset;
    srst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rd_data_o;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(nm, d, exp);
  endtask

  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while (tick !== 1'b1 && n < 100);
    if (n >= 100) begin
      bad_count++;
      $display("Error tick timeout");
      report_and_stop();
    end
  endtask

  task automatic send_line(input logic b, input logic s);
    int n;
    @(posedge clk_i);
    go <= 1'b1;
    bad <= b;
    slow <= s;
    @(posedge clk_i);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (busy !== 1'b0 && n < 50);
    if (n >= 50) begin
      bad_count++;
      $display("Error line timeout");
      report_and_stop();
    end
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // mode writes and the tick period each must produce, base n+1 = 3
  logic [7:0] mode_tab [3] = '{8'h00, 8'h40, 8'h50};
  int         per_tab  [3] = '{12, 6, 2};
  int         n;

  initial begin
    do_reset();
    rd_chk("mode strap", RMS_MODE_ADDR, 8'h34);
    chk("audio auto", {7'h00, audio}, 8'h01);
    chk("repeater", {7'h00, rep}, 8'h01);
    chk("fast strap", {7'h00, fast}, 8'h01);
    chk("rate fast", {6'h00, rate}, {6'h00, RMS_RATE_FAST});
    wait_tick(n);
    wait_tick(n);
    chk("fast period", n[7:0], 8'h02);
    wr(RMS_MODE_ADDR, 8'hFF);
    rd_chk("mode all", RMS_MODE_ADDR, 8'hFC);
    chk("coax", {7'h00, coax}, 8'h01);
    @(posedge clk_i);
    #1 chk("rd idle", rd_data_o, 8'h00);
    wr(RMS_MODE_ADDR, 8'h03);
    rd_chk("mode ro", RMS_MODE_ADDR, 8'h04);
    chk("coax off", {7'h00, coax}, 8'h00);
    chk("audio off", {7'h00, audio}, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(RMS_MODE_ADDR, mode_tab[i]);
      wait_tick(n);
      wait_tick(n);
      chk("rate period", n[7:0], per_tab[i][7:0]);
    end
    chk("pick", {7'h00, pick}, 8'h01);
    // divider value zero gives a one-cycle base
    @(posedge clk_i);
    osc_n <= 8'h00;
    wr(RMS_MODE_ADDR, 8'h00);
    wait_tick(n);
    wait_tick(n);
    chk("base one", n[7:0], 8'h04);
    // rate change sets the change flag; clear it before line tests
    wr(RMS_MODE_ADDR, 8'h80);
    rd_chk("rate chg", RMS_CPS_ADDR, 8'h02);
    chk("chk en", {7'h00, chk_en}, 8'h01);
    wr(RMS_CPS_ADDR, 8'h03);
    rd_chk("status clr", RMS_CPS_ADDR, 8'h00);
    wr(RMS_MASK_ADDR, 8'h01);
    rd_chk("mask", RMS_MASK_ADDR, 8'h01);
    send_line(1'b0, 1'b0);
    rd_chk("good line", RMS_CPS_ADDR, 8'h00);
    send_line(1'b1, 1'b1);
    chk("irq set", {7'h00, irq}, 8'h01);
    rd_chk("bad line", RMS_CPS_ADDR, 8'h01);
    rd_chk("mode kept", RMS_MODE_ADDR, 8'h84);
    wr(RMS_MASK_ADDR, 8'h00);
    repeat (2) @(posedge clk_i);
    #1 chk("irq masked", {7'h00, irq}, 8'h00);
    wr(RMS_CPS_ADDR, 8'h01);
    rd_chk("status w1c", RMS_CPS_ADDR, 8'h00);
    wr(RMS_MODE_ADDR, 8'h00);
    send_line(1'b1, 1'b0);
    rd_chk("chk off", RMS_CPS_ADDR, 8'h00);
    rd_chk("unmapped", 8'h55, 8'h00);
    @(posedge clk_i);
    strap <= 3'h2;
    do_reset();
    rd_chk("mode restrap", RMS_MODE_ADDR, 8'h28);
    chk("coax strap", {7'h00, coax}, 8'h01);
    report_and_stop();
  end
endmodule // tb_rms_mode_reg_top
`default_nettype wire
